/* File: rtl/pefmux_pkg.sv */
// Package of constants for the port E top pin and port F pin logic.
// ----------------------------------------------------------------------
// Summary of operation
// - With the capture unit routed to the port E top pin, direction 0 lets its compare/PWM output override the latch and direction 1 feeds the pin to its capture input.
// - The capture unit appears on the port E top pin only when the pin select bit is cleared.
// - PWM output A on the port E top pin can be tri-stated while a PWM shutdown is active, when that option is enabled.
// - An enabled LCD segment 31 turns off the top pin's digital driver and hands the pin to the analog segment.
// - Functions whose direction is don't-care override the direction bit when selected.
// - Small-memory parts lack the open-drain bits of the two highest capture units; 64-pin parts lack the largest port pull-up bit.
// - Port F has 7 pins, 1 to 7, each with its own direction, latch and read bit.
// - Every port F pin input passes a Schmitt-trigger stage before it is sampled.
// - After reset port F pins 7 to 1 are analog inputs and read as 0 until made digital.
// - A port F pin is general I/O only while its LCD segment enable is clear.
// - Direction 1 makes a pin an input and 0 makes it an output.
// ----------------------------------------------------------------------
package pefmux_pkg;
    localparam logic [7:0] ADDR_PORT_E_PIN_LEVELS = 8'h00;
    localparam logic [7:0] ADDR_PORT_E_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] ADDR_PORT_E_DIRECTION = 8'h08;
    localparam logic [7:0] ADDR_PORT_F_PIN_LEVELS = 8'h0C;
    localparam logic [7:0] ADDR_PORT_F_OUTPUT_LATCH = 8'h10;
    localparam logic [7:0] ADDR_PORT_F_DIRECTION = 8'h14;
    localparam logic [7:0] ADDR_LCD_CONTROL = 8'h18;
    localparam logic [7:0] ADDR_LCD_SEGMENT_ENABLE_MID = 8'h1C;
    localparam logic [7:0] ADDR_LCD_SEGMENT_ENABLE_HI = 8'h20;
    localparam logic [7:0] ADDR_OPEN_DRAIN_CONTROL_A = 8'h24;
    localparam logic [7:0] ADDR_OPEN_DRAIN_CONTROL_B = 8'h28;
    localparam logic [7:0] ADDR_PAD_CONFIGURATION = 8'h2C;
    localparam logic [7:0] ADDR_ANALOG_SELECT_A = 8'h30;
    localparam logic [7:0] ADDR_ANALOG_SELECT_B = 8'h34;
    localparam logic [7:0] ADDR_COMPARATOR_CONTROL = 8'h38;
    localparam logic [7:0] ADDR_PIN_CONFIG = 8'h3C;
    // Reset values.
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ANALOG_SELECT = 8'hFF;
    localparam logic [7:0] RST_PIN_CONFIG = 8'h01;
    // Writable masks; unimplemented bits read as zero.
    localparam logic [7:0] MASK_LCD_CONTROL = 8'hEF;
    localparam logic [7:0] MASK_ODC_A = 8'hE1;
    localparam logic [7:0] MASK_ODC_B_FULL = 8'hFF;
    localparam logic [7:0] MASK_ODC_B_SMALL = 8'h3F;
    localparam logic [7:0] MASK_PAD_FULL = 8'hE6;
    localparam logic [7:0] MASK_PAD_SMALL = 8'hC6;
    localparam logic [7:0] MASK_PORT_F = 8'hFE;
    // Field positions.
    localparam int TOP_PIN = 7;
    localparam int LCD_SEGMENT_31_OUTPUT_BIT = 7;
    localparam int PINCFG_SEL_BIT = 0;
    localparam int PINCFG_TRI_BIT = 1;
    // Analog-select bit for each port F pin 1..7: pin1=AN6 ... pin7=AN5.
    localparam int ANSEL_IDX [1:7] = '{6, 7, 8, 9, 10, 11, 5};
    // Segment index for each port F pin 1..7: segments 19..25.
    localparam int SEG_IDX [1:7] = '{19, 20, 21, 22, 23, 24, 25};
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: rtl/pefmux_sync.sv */
// Two-stage synchroniser for a bus of pin inputs.
`timescale 1ns/1ps
module pefmux_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    // The Schmitt stage sits in the pad; here the level is resampled.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
        end
    end
    assign q_o = s2_reg;
endmodule // pefmux_sync

/* File: rtl/pefmux_top.sv */
// Port E top pin and port F pin logic with an AXI4-Lite register slave.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module pefmux_top
    import pefmux_pkg::*;
#(
    parameter bit SMALL_MEMORY = 1'b0,
    parameter bit PINS_64 = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Port E pins, all eight levels read, only the top pin driven here
    input wire logic [7:0] port_e_pad_i,
    output logic port_e_top_pin_o,
    output logic port_e_top_pin_oe_n_o,
    // Port F pins 1..7 (bit 0 unused)
    input wire logic [7:0] port_f_pad_i,
    output logic [7:0] port_f_pad_o,
    output logic [7:0] port_f_pad_oe_n_o,
    output logic [7:0] port_f_analog_o,
    // Capture unit two and its PWM output A
    input wire logic ccp2_compare_i,
    input wire logic ccp2_pwm_active_i,
    input wire logic pwm_shutdown_i,
    output logic ccp2_capture_o,
    // LCD segment 31 handover
    output logic lcd_segment_31_output_o,
    // Comparator outputs driven onto pins 1 and 2
    input wire logic [1:0] comparator_out_i
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] e_lat_reg, e_lat_next, e_dir_reg, e_dir_next;
    logic [7:0] f_lat_reg, f_lat_next, f_dir_reg, f_dir_next;
    logic [7:0] lcd_control_reg, lcd_control_next, se2_reg, se2_next;
    logic [7:0] se3_reg, se3_next, odca_reg, odca_next;
    logic [7:0] odcb_reg, odcb_next, pad_reg, pad_next;
    logic [7:0] ansa_reg, ansa_next, ansb_reg, ansb_next;
    logic [7:0] comparator_control_reg, comparator_control_next, pcfg_reg, pcfg_next;
    logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next;
    logic rv_reg, rv_next;
    logic [7:0] awa_reg, awa_next, wd_reg, wd_next;
    logic ws_reg, ws_next;
    logic [31:0] rd_reg, rd_next;
    logic [1:0] br_reg, br_next, rr_reg, rr_next;
    logic [7:0] e_sync, f_sync;
    logic [15:0] ansel_all;
    logic [7:0] f_digital, f_seg, f_read, odcb_mask, pad_mask;
    logic do_write;

    assign odcb_mask = SMALL_MEMORY ? MASK_ODC_B_SMALL : MASK_ODC_B_FULL;
    assign pad_mask = PINS_64 ? MASK_PAD_SMALL : MASK_PAD_FULL;
    assign ansel_all = {ansb_reg, ansa_reg};

    pefmux_sync #(.WIDTH(16)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i({port_f_pad_i, port_e_pad_i}),
        .q_o({f_sync, e_sync})
    );

    // ------------------------------------------------------------------
    // Port F per-pin decode
    // ------------------------------------------------------------------
    assign f_digital[0] = 1'b0;
    assign f_seg[0] = 1'b0;
    assign f_read[0] = 1'b0;
    for (genvar i = 1; i < 8; i++) begin : g_pf
        // Segments 19..23 in mid register, 24..25 in high register.
        if (SEG_IDX[i] < 24) begin : g_mid
            assign f_seg[i] = se2_reg[SEG_IDX[i] - 16];
        end else begin : g_hi
            assign f_seg[i] = se3_reg[SEG_IDX[i] - 24];
        end
        assign f_digital[i] = ~ansel_all[ANSEL_IDX[i]];
        assign f_read[i] = f_digital[i] & ~f_seg[i] & f_sync[i];
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    assign do_write = aw_reg & w_reg & ~bv_reg;

    always_comb begin
        aw_next = aw_reg;
        w_next = w_reg;
        awa_next = awa_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        rv_next = rv_reg;
        rr_next = rr_reg;
        rd_next = rd_reg;
        e_lat_next = e_lat_reg;
        e_dir_next = e_dir_reg;
        f_lat_next = f_lat_reg;
        f_dir_next = f_dir_reg;
        lcd_control_next = lcd_control_reg;
        se2_next = se2_reg;
        se3_next = se3_reg;
        odca_next = odca_reg;
        odcb_next = odcb_reg;
        pad_next = pad_reg;
        ansa_next = ansa_reg;
        ansb_next = ansb_reg;
        comparator_control_next = comparator_control_reg;
        pcfg_next = pcfg_reg;
        if (s_axi_awvalid_i && !aw_reg) begin
            aw_next = 1'b1;
            awa_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_reg) begin
            w_next = 1'b1;
            wd_next = s_axi_wdata_i[7:0];
            ws_next = s_axi_wstrb_i[0];
        end
        if (do_write) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bv_next = 1'b1;
            br_next = RESP_OKAY;
            if (!ws_reg) begin
                br_next = RESP_OKAY;
            end else if (awa_reg == ADDR_PORT_E_PIN_LEVELS ||
                         awa_reg == ADDR_PORT_E_OUTPUT_LATCH) begin
                e_lat_next = wd_reg;
            end else if (awa_reg == ADDR_PORT_E_DIRECTION) begin
                e_dir_next = wd_reg;
            end else if (awa_reg == ADDR_PORT_F_PIN_LEVELS ||
                         awa_reg == ADDR_PORT_F_OUTPUT_LATCH) begin
                f_lat_next = wd_reg & MASK_PORT_F;
            end else if (awa_reg == ADDR_PORT_F_DIRECTION) begin
                f_dir_next = wd_reg & MASK_PORT_F;
            end else if (awa_reg == ADDR_LCD_CONTROL) begin
                lcd_control_next = wd_reg & MASK_LCD_CONTROL;
            end else if (awa_reg == ADDR_LCD_SEGMENT_ENABLE_MID) begin
                se2_next = wd_reg;
            end else if (awa_reg == ADDR_LCD_SEGMENT_ENABLE_HI) begin
                se3_next = wd_reg;
            end else if (awa_reg == ADDR_OPEN_DRAIN_CONTROL_A) begin
                odca_next = wd_reg & MASK_ODC_A;
            end else if (awa_reg == ADDR_OPEN_DRAIN_CONTROL_B) begin
                odcb_next = wd_reg & odcb_mask;
            end else if (awa_reg == ADDR_PAD_CONFIGURATION) begin
                pad_next = wd_reg & pad_mask;
            end else if (awa_reg == ADDR_ANALOG_SELECT_A) begin
                ansa_next = wd_reg;
            end else if (awa_reg == ADDR_ANALOG_SELECT_B) begin
                ansb_next = wd_reg;
            end else if (awa_reg == ADDR_COMPARATOR_CONTROL) begin
                comparator_control_next = wd_reg;
            end else if (awa_reg == ADDR_PIN_CONFIG) begin
                pcfg_next = wd_reg & 8'h03;
            end else begin
                br_next = RESP_SLVERR;
            end
        end
        if (bv_reg && s_axi_bready_i) begin
            bv_next = 1'b0;
        end
        if (rv_reg && s_axi_rready_i) begin
            rv_next = 1'b0;
        end else if (s_axi_arvalid_i && !rv_reg) begin
            rv_next = 1'b1;
            rr_next = RESP_OKAY;
            rd_next = 32'h0000_0000;
            if (s_axi_araddr_i == ADDR_PORT_E_PIN_LEVELS) begin
                rd_next[7:0] = e_sync;
            end else if (s_axi_araddr_i == ADDR_PORT_E_OUTPUT_LATCH) begin
                rd_next[7:0] = e_lat_reg;
            end else if (s_axi_araddr_i == ADDR_PORT_E_DIRECTION) begin
                rd_next[7:0] = e_dir_reg;
            end else if (s_axi_araddr_i == ADDR_PORT_F_PIN_LEVELS) begin
                rd_next[7:0] = f_read;
            end else if (s_axi_araddr_i == ADDR_PORT_F_OUTPUT_LATCH) begin
                rd_next[7:0] = f_lat_reg;
            end else if (s_axi_araddr_i == ADDR_PORT_F_DIRECTION) begin
                rd_next[7:0] = f_dir_reg;
            end else if (s_axi_araddr_i == ADDR_LCD_CONTROL) begin
                rd_next[7:0] = lcd_control_reg;
            end else if (s_axi_araddr_i == ADDR_LCD_SEGMENT_ENABLE_MID) begin
                rd_next[7:0] = se2_reg;
            end else if (s_axi_araddr_i == ADDR_LCD_SEGMENT_ENABLE_HI) begin
                rd_next[7:0] = se3_reg;
            end else if (s_axi_araddr_i == ADDR_OPEN_DRAIN_CONTROL_A) begin
                rd_next[7:0] = odca_reg;
            end else if (s_axi_araddr_i == ADDR_OPEN_DRAIN_CONTROL_B) begin
                rd_next[7:0] = odcb_reg;
            end else if (s_axi_araddr_i == ADDR_PAD_CONFIGURATION) begin
                rd_next[7:0] = pad_reg;
            end else if (s_axi_araddr_i == ADDR_ANALOG_SELECT_A) begin
                rd_next[7:0] = ansa_reg;
            end else if (s_axi_araddr_i == ADDR_ANALOG_SELECT_B) begin
                rd_next[7:0] = ansb_reg;
            end else if (s_axi_araddr_i == ADDR_COMPARATOR_CONTROL) begin
                rd_next[7:0] = comparator_control_reg;
            end else if (s_axi_araddr_i == ADDR_PIN_CONFIG) begin
                rd_next[7:0] = pcfg_reg;
            end else begin
                rr_next = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            awa_reg <= RST_ZERO;
            wd_reg <= RST_ZERO;
            ws_reg <= 1'b0;
            bv_reg <= 1'b0;
            br_reg <= RESP_OKAY;
            rv_reg <= 1'b0;
            rr_reg <= RESP_OKAY;
            rd_reg <= 32'h0000_0000;
            e_lat_reg <= RST_ZERO;
            e_dir_reg <= RST_DIRECTION;
            f_lat_reg <= RST_ZERO;
            f_dir_reg <= RST_DIRECTION & MASK_PORT_F;
            lcd_control_reg <= RST_ZERO;
            se2_reg <= RST_ZERO;
            se3_reg <= RST_ZERO;
            odca_reg <= RST_ZERO;
            odcb_reg <= RST_ZERO;
            pad_reg <= RST_ZERO;
            ansa_reg <= RST_ANALOG_SELECT;
            ansb_reg <= RST_ANALOG_SELECT;
            comparator_control_reg <= RST_ZERO;
            pcfg_reg <= RST_PIN_CONFIG;
        end else begin
            aw_reg <= aw_next;
            w_reg <= w_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            bv_reg <= bv_next;
            br_reg <= br_next;
            rv_reg <= rv_next;
            rr_reg <= rr_next;
            rd_reg <= rd_next;
            e_lat_reg <= e_lat_next;
            e_dir_reg <= e_dir_next;
            f_lat_reg <= f_lat_next;
            f_dir_reg <= f_dir_next;
            lcd_control_reg <= lcd_control_next;
            se2_reg <= se2_next;
            se3_reg <= se3_next;
            odca_reg <= odca_next;
            odcb_reg <= odcb_next;
            pad_reg <= pad_next;
            ansa_reg <= ansa_next;
            ansb_reg <= ansb_next;
            comparator_control_reg <= comparator_control_next;
            pcfg_reg <= pcfg_next;
        end
    end

    // ------------------------------------------------------------------
    // Pin multiplexing
    // ------------------------------------------------------------------
    // Pin drivers are registered so every output comes from a flip-flop;
    // this costs one cycle of latency from a register write to the pad.
    logic top_q_reg, top_q_next, top_oe_n_reg, top_oe_n_next;
    logic lcd_segment_31_output_reg, lcd_segment_31_output_next, cap_reg, cap_next;
    logic [7:0] pf_q_reg, pf_q_next, pf_oe_n_reg, pf_oe_n_next;
    logic [7:0] pf_an_reg, pf_an_next;
    logic ccp_sel, lcd_segment_31_output_on;

    assign ccp_sel = ~pcfg_reg[PINCFG_SEL_BIT];
    assign lcd_segment_31_output_on = se3_reg[LCD_SEGMENT_31_OUTPUT_BIT];

    always_comb begin
        top_q_next = e_lat_reg[TOP_PIN];
        top_oe_n_next = e_dir_reg[TOP_PIN];
        cap_next = 1'b0;
        lcd_segment_31_output_next = lcd_segment_31_output_on;
        if (lcd_segment_31_output_on) begin
            top_oe_n_next = 1'b1;
        end else if (ccp_sel && !e_dir_reg[TOP_PIN]) begin
            top_q_next = ccp2_compare_i;
            if (ccp2_pwm_active_i && pwm_shutdown_i &&
                pcfg_reg[PINCFG_TRI_BIT]) begin
                top_oe_n_next = 1'b1;
            end
        end else if (ccp_sel) begin
            cap_next = e_sync[TOP_PIN];
        end
        pf_q_next = f_lat_reg;
        pf_oe_n_next = f_dir_reg | ~MASK_PORT_F;
        pf_an_next = ~f_digital | f_seg;
        for (int k = 1; k < 3; k++) begin
            if (comparator_control_reg[k - 1] && !f_dir_reg[k]) begin
                pf_q_next[k] = comparator_out_i[k - 1];
            end
        end
        for (int k = 1; k < 8; k++) begin
            if (f_seg[k]) begin
                pf_oe_n_next[k] = 1'b1;
            end
        end
        pf_an_next[0] = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            top_q_reg <= 1'b0;
            top_oe_n_reg <= 1'b1;
            cap_reg <= 1'b0;
            lcd_segment_31_output_reg <= 1'b0;
            pf_q_reg <= RST_ZERO;
            pf_oe_n_reg <= RST_DIRECTION;
            pf_an_reg <= MASK_PORT_F;
        end else begin
            top_q_reg <= top_q_next;
            top_oe_n_reg <= top_oe_n_next;
            cap_reg <= cap_next;
            lcd_segment_31_output_reg <= lcd_segment_31_output_next;
            pf_q_reg <= pf_q_next;
            pf_oe_n_reg <= pf_oe_n_next;
            pf_an_reg <= pf_an_next;
        end
    end

    assign port_e_top_pin_o = top_q_reg;
    assign port_e_top_pin_oe_n_o = top_oe_n_reg;
    assign ccp2_capture_o = cap_reg;
    assign lcd_segment_31_output_o = lcd_segment_31_output_reg;
    assign port_f_pad_o = pf_q_reg;
    assign port_f_pad_oe_n_o = pf_oe_n_reg;
    assign port_f_analog_o = pf_an_reg;
    assign s_axi_awready_o = ~aw_reg;
    assign s_axi_wready_o = ~w_reg;
    assign s_axi_bvalid_o = bv_reg;
    assign s_axi_bresp_o = br_reg;
    assign s_axi_arready_o = ~rv_reg;
    assign s_axi_rvalid_o = rv_reg;
    assign s_axi_rresp_o = rr_reg;
    assign s_axi_rdata_o = rd_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb_main @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_seg_drv_off: assert property (
        se3_reg[LCD_SEGMENT_31_OUTPUT_BIT] |=> port_e_top_pin_oe_n_o)
        else $error("Segment 31 on but top pin driven.");
    a_ccp_override: assert property (
        (ccp_sel && !e_dir_reg[TOP_PIN] && !lcd_segment_31_output_on)
        |=> port_e_top_pin_o == $past(ccp2_compare_i))
        else $error("Compare output not on top pin.");
    a_default_pin: assert property (
        (!ccp_sel && !lcd_segment_31_output_on)
        |=> port_e_top_pin_o == $past(e_lat_reg[TOP_PIN]))
        else $error("Latch not on top pin when routed away.");
    a_pwm_tristate: assert property (
        (ccp_sel && !e_dir_reg[TOP_PIN] && pwm_shutdown_i &&
        ccp2_pwm_active_i && pcfg_reg[PINCFG_TRI_BIT])
        |=> port_e_top_pin_oe_n_o)
        else $error("Top pin driven during shutdown.");
    a_pf_read_zero: assert property (
        (rv_reg && !$past(rv_reg) &&
        $past(s_axi_araddr_i) == ADDR_PORT_F_PIN_LEVELS)
        |-> (s_axi_rdata_o[7:1] & ~f_digital[7:1]) == 7'h00)
        else $error("Analog port F pin read non-zero.");
    a_pf_seg_off: assert property (
        f_seg[3] |=> port_f_pad_oe_n_o[3])
        else $error("Segment pin still driven.");
    a_pf_dir: assert property (
        (!f_seg[4] && !f_dir_reg[4]) |=> !port_f_pad_oe_n_o[4])
        else $error("Output pin not driven.");
    a_latch_write: assert property (
        (do_write && ws_reg && awa_reg == ADDR_PORT_F_PIN_LEVELS)
        |=> f_lat_reg == ($past(wd_reg) & MASK_PORT_F))
        else $error("Port write missed the latch.");
    a_bit0_absent: assert property (
        !f_lat_reg[0] && !f_dir_reg[0] && !port_f_analog_o[0])
        else $error("Port F bit 0 implemented.");
    a_odcb_small: assert property (
        SMALL_MEMORY |-> odcb_reg[7:6] == 2'b00)
        else $error("Absent open-drain bits set.");
    c_write: cover property (do_write);
    c_read: cover property (rv_reg && s_axi_rready_i);
    c_lcd_segment_31_output: cover property (lcd_segment_31_output_reg);
    c_shutdown: cover property (
        ccp_sel && pwm_shutdown_i && pcfg_reg[PINCFG_TRI_BIT]);
endmodule // pefmux_top

/* File: tb/pefmux_pads.sv */
// Board-side pin model joining the block's drivers to external levels.
`timescale 1ns/1ps
module pefmux_pads (
    // Block pin drivers
    input wire logic e_top_i,
    input wire logic e_top_oe_n_i,
    input wire logic [7:0] f_out_i,
    input wire logic [7:0] f_oe_n_i,
    // External levels
    input wire logic [7:0] ext_e_i,
    input wire logic [7:0] ext_f_i,
    // Pad levels seen by the block
    output logic [7:0] e_pad_o,
    output logic [7:0] f_pad_o
);
    // A driven pin shows the block's level, an input pin the board's.
    assign e_pad_o[7] = e_top_oe_n_i ? ext_e_i[7] : e_top_i;
    assign e_pad_o[6:0] = ext_e_i[6:0];
    assign f_pad_o = (f_out_i & ~f_oe_n_i) | (ext_f_i & f_oe_n_i);
endmodule // pefmux_pads

/* File: tb/tb_top.sv */
// Register-level bench for the port E top pin and port F pin logic.
`timescale 1ns/1ps
module tb_top;
    import pefmux_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext_e = 8'h00, ext_f = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, cmp = 1'b0, pwm = 1'b0, shut = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, e_top, e_oe_n, cap, lcd_segment_31_output;
    logic [7:0] e_pad, f_pad, f_out, f_oe_n, f_ana;
    int failures = 0, checked = 0, cycles = 0;
    pefmux_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .port_e_pad_i(e_pad),
        .port_e_top_pin_o(e_top), .port_e_top_pin_oe_n_o(e_oe_n),
        .port_f_pad_i(f_pad), .port_f_pad_o(f_out),
        .port_f_pad_oe_n_o(f_oe_n), .port_f_analog_o(f_ana),
        .ccp2_compare_i(cmp), .ccp2_pwm_active_i(pwm),
        .pwm_shutdown_i(shut), .ccp2_capture_o(cap),
        .lcd_segment_31_output_o(lcd_segment_31_output), .comparator_out_i(2'h0));
    pefmux_pads u_pads (.e_top_i(e_top), .e_top_oe_n_i(e_oe_n),
        .f_out_i(f_out), .f_oe_n_i(f_oe_n), .ext_e_i(ext_e),
        .ext_f_i(ext_f), .e_pad_o(e_pad), .f_pad_o(f_pad));
    // ----------------------------------------------------------------
    // Bus tasks and checks
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk({rresp, rdata}, {r, 24'h000000, d});
    endtask
    // Pins settle after two sync stages plus the output register.
    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask
    task automatic stop_test();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        ext_f <= 8'hFF;
        rd(ADDR_PORT_F_DIRECTION, 8'hFE, RESP_OKAY);
        rd(ADDR_ANALOG_SELECT_B, RST_ANALOG_SELECT, RESP_OKAY);
        rd(ADDR_PORT_F_PIN_LEVELS, 8'h00, RESP_OKAY);
        rd(8'h40, 8'h00, RESP_SLVERR);
        wr(8'h40, 8'hFF);
        chk(bresp, RESP_SLVERR);
        wr(ADDR_COMPARATOR_CONTROL, 8'h00);
        wr(ADDR_ANALOG_SELECT_A, 8'h00);
        wr(ADDR_ANALOG_SELECT_B, 8'h00);
        wr(ADDR_PORT_F_DIRECTION, 8'hCE);
        wr(ADDR_PORT_F_PIN_LEVELS, 8'hFF);
        rd(ADDR_PORT_F_OUTPUT_LATCH, 8'hFE, RESP_OKAY);
        ext_f <= 8'hAA;
        settle();
        rd(ADDR_PORT_F_PIN_LEVELS, 8'hBA, RESP_OKAY);
        chk(f_oe_n, 8'hCF);
        wr(ADDR_COMPARATOR_CONTROL, 8'h01);
        wr(ADDR_PORT_F_DIRECTION, 8'hCC);
        settle();
        chk(f_out, 8'hFC);
        wr(ADDR_COMPARATOR_CONTROL, 8'h00);
        wr(ADDR_PORT_F_OUTPUT_LATCH, 8'h00);
        wr(ADDR_LCD_SEGMENT_ENABLE_MID, 8'h08);
        settle();
        chk({f_out, f_ana}, 16'h0002);
        rd(ADDR_PORT_F_PIN_LEVELS, 8'h88, RESP_OKAY);
        wr(ADDR_PIN_CONFIG, 8'h00);
        wr(ADDR_PORT_E_DIRECTION, 8'h7F);
        cmp <= 1'b1;
        settle();
        chk({e_oe_n, e_top}, 2'h1);
        pwm <= 1'b1;
        shut <= 1'b1;
        wr(ADDR_PIN_CONFIG, 8'h02);
        settle();
        chk(e_oe_n, 1'b1);
        pwm <= 1'b0;
        shut <= 1'b0;
        wr(ADDR_PIN_CONFIG, 8'h01);
        settle();
        chk({e_oe_n, e_top}, 2'h0);
        wr(ADDR_PIN_CONFIG, 8'h00);
        wr(ADDR_PORT_E_DIRECTION, 8'hFF);
        ext_e <= 8'h80;
        settle();
        chk(cap, 1'b1);
        rd(ADDR_PORT_E_PIN_LEVELS, 8'h80, RESP_OKAY);
        wr(ADDR_PORT_E_DIRECTION, 8'h7F);
        wr(ADDR_LCD_SEGMENT_ENABLE_HI, 8'h80);
        settle();
        chk({lcd_segment_31_output, e_oe_n}, 2'h3);
        stop_test();
    end
endmodule // tb_top
